// ===== src/picic_consts.vh
// Purpose: constants of the priority interrupt controller
// Assumes: 16-bit register data, 32-bit byte addresses
// Notes:   definitions only
`ifndef PICIC_CONSTS_VH
`define PICIC_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// register addresses
`define PICIC_A_EXT_PEND   32'h04000004
`define PICIC_A_PEND_2     32'h04000006
`define PICIC_A_PEND_3     32'h04000008
`define PICIC_A_SENSE      32'h04000010
`define PICIC_A_AUX        32'h04000012
`define PICIC_A_PORT_EN    32'h04000014
`define PICIC_A_PRIO_C     32'h04000016
`define PICIC_A_PRIO_D     32'h04000018
`define PICIC_A_PRIO_E     32'h0400001A
`define PICIC_A_NMI_CTL    32'hFFFFFEE0
`define PICIC_A_PRIO_A     32'hFFFFFEE2
`define PICIC_A_PRIO_B     32'hFFFFFEE4

////////////////////////////////////////////////////////////////////////
// reset values and field positions
`define PICIC_RST16        16'h0000
`define PICIC_RST8         8'h00
`define PICIC_NMIL_BIT     15
`define PICIC_NONMASKABLE_EDGE_SELECT_BIT     8
`define PICIC_MAI_BIT      15
`define PICIC_LVL2_BIT     14
`define PICIC_BLOCK_OVERRIDE_BIT_BIT    13
`define PICIC_IRLSEN_BIT   12

////////////////////////////////////////////////////////////////////////
// line sense codes, two bits per external line
`define PICIC_SNS_FALL     2'h0
`define PICIC_SNS_RISE     2'h1

////////////////////////////////////////////////////////////////////////
// priorities and timing
`define PICIC_PRIO_NMI     5'h10
`define PICIC_PRIO_NONE    5'h00
`define PICIC_NMI_HOLD     5'h14
`define PICIC_SRC_NMI      5'h1F
`define PICIC_WAKE_LINES   5

`endif

// ===== src/picic_line_det.v
// Purpose: one external request line, level or edge sensed
// Assumes: pin synchronous to clk
// Notes:   edge flag set wins over a clear in the same cycle
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_line_det (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // line and control
  input  wire       pin,
  input  wire [1:0] sense,
  input  wire       clr,
  // status
  output wire       flag
);

  reg  prev_q;
  reg  edge_q;
  wire is_edge;
  wire hit;

  assign is_edge = (sense == `PICIC_SNS_FALL) || (sense == `PICIC_SNS_RISE);
  assign hit     = (sense == `PICIC_SNS_RISE) ? (pin & ~prev_q) : (~pin & prev_q);

  always @(posedge clk) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      prev_q <= pin;
      if (is_edge && hit) begin
        edge_q <= 1'b1;
      end else if (clr || !is_edge) begin
        edge_q <= 1'b0;
      end
    end
  end

  // level mode is active low on the pin
  assign flag = is_edge ? edge_q : ~pin;

endmodule

// ===== src/picic_irl_filter.v
// Purpose: noise filter and inverse decode of an encoded level bus
// Assumes: pins synchronous to clk
// Notes:   a value must hold two samples before it is believed
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_irl_filter (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // pins
  input  wire [3:0] pins,
  input  wire       enable,
  // decoded priority
  output wire [3:0] level
);

  reg [3:0] samp_q;
  reg [3:0] filt_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      samp_q <= 4'hF;
      filt_q <= 4'hF;
    end else begin
      samp_q <= pins;
      if (samp_q == pins) begin
        filt_q <= pins;
      end
    end
  end

  // 0000 is level 15, 1111 is no request
  assign level = enable ? ~filt_q : 4'h0;

endmodule

// ===== src/picic_top.v
// Purpose: priority interrupt controller, requests to the cpu core
// Assumes: all inputs synchronous to clk; 16-bit register port
// Notes:   read data valid the cycle after the read strobe
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_top #(
  parameter NPER = 12
) (
  // clock and reset
  input  wire            clk,
  input  wire            sys_rst,
  // register port
  input  wire [31:0]     reg_addr,
  input  wire [15:0]     reg_wdata,
  input  wire            reg_wr,
  input  wire            reg_rd,
  output wire [15:0]     reg_rdata,
  // request sources
  input  wire            nmi_pin,
  input  wire [5:0]      ext_request_lines,
  input  wire [3:0]      encoded_level_lines,
  input  wire [3:0]      second_encoded_level_lines,
  input  wire [15:0]     port_request_lines,
  input  wire [NPER-1:0] periph_req,
  input  wire            refresh_req,
  // cpu core state
  input  wire [3:0]      processor_mask_level,
  input  wire            exception_block_flag,
  input  wire            sleep_mode,
  input  wire            standby_mode,
  input  wire            rtc_osc_on,
  input  wire            bus_released,
  input  wire            nmi_ack,
  // cpu requests
  output wire            cpu_req,
  output wire [4:0]      cpu_level,
  output wire [4:0]      cpu_src,
  output wire            wakeup,
  output wire            bus_request_notify
);

  localparam NSRC = 9 + NPER;

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg        nonmaskable_edge_select_q;
  reg [15:0] line_sense_control_q;
  reg [15:0] line_aux_control_q;
  reg [15:0] port_request_enable_q;
  reg [15:0] priority_set_a_q;
  reg [15:0] priority_set_b_q;
  reg [15:0] priority_set_c_q;
  reg [15:0] priority_set_d_q;
  reg [15:0] priority_set_e_q;
  reg [5:0]  read_one_q;
  reg [15:0] rdata_q;
  reg [15:0] rdata_d;

  // nonmaskable path
  reg        nmi_prev_q;
  reg        nmi_pend_q;
  reg [4:0]  nmi_hold_q;

  wire       disable_all_bit;
  wire       block_override_bit;
  wire       lvl2_en;
  wire [5:0] ext_flag;
  wire [5:0] ext_clr;
  wire [7:0] ext_pending_flags;
  wire [7:0] pending_flags_second;
  wire [7:0] pending_flags_third;
  wire [15:0] nmi_ctl_rd;
  wire       wr_pend;
  wire       wr_nmi;

  assign disable_all_bit     = line_sense_control_q[`PICIC_MAI_BIT];
  assign block_override_bit   = line_sense_control_q[`PICIC_BLOCK_OVERRIDE_BIT_BIT];
  assign lvl2_en = line_sense_control_q[`PICIC_LVL2_BIT] & line_sense_control_q[`PICIC_IRLSEN_BIT];
  assign wr_pend = reg_wr && (reg_addr == `PICIC_A_EXT_PEND);
  assign wr_nmi  = reg_wr && (reg_addr == `PICIC_A_NMI_CTL);

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      nonmaskable_edge_select_q                <= 1'b0;
      line_sense_control_q  <= `PICIC_RST16;
      line_aux_control_q    <= `PICIC_RST16;
      port_request_enable_q <= `PICIC_RST16;
      priority_set_a_q      <= `PICIC_RST16;
      priority_set_b_q      <= `PICIC_RST16;
      priority_set_c_q      <= `PICIC_RST16;
      priority_set_d_q      <= `PICIC_RST16;
      priority_set_e_q      <= `PICIC_RST16;
    end else if (reg_wr) begin
      case (reg_addr)
        `PICIC_A_NMI_CTL: nonmaskable_edge_select_q                <= reg_wdata[`PICIC_NONMASKABLE_EDGE_SELECT_BIT];
        `PICIC_A_SENSE:   line_sense_control_q  <= reg_wdata;
        `PICIC_A_AUX:     line_aux_control_q    <= reg_wdata;
        `PICIC_A_PORT_EN: port_request_enable_q <= reg_wdata;
        `PICIC_A_PRIO_A:  priority_set_a_q      <= reg_wdata;
        `PICIC_A_PRIO_B:  priority_set_b_q      <= reg_wdata;
        `PICIC_A_PRIO_C:  priority_set_c_q      <= reg_wdata;
        `PICIC_A_PRIO_D:  priority_set_d_q      <= reg_wdata;
        `PICIC_A_PRIO_E:  priority_set_e_q      <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external lines: an edge flag drops only if it was read as one
  // since the last clear, so a newer edge read as zero survives
  assign ext_clr = (wr_pend ? ~reg_wdata[5:0] : 6'h00) & read_one_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      read_one_q <= 6'h00;
    end else if (reg_rd && (reg_addr == `PICIC_A_EXT_PEND)) begin
      read_one_q <= ext_flag;
    end else begin
      read_one_q <= read_one_q & ~ext_clr;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_line
      picic_line_det u_det (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (ext_request_lines[g]),
        .sense   (line_sense_control_q[2*g+1:2*g]),
        .clr     (ext_clr[g]),
        .flag    (ext_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // encoded level lines, the second set only when enabled
  wire [3:0] irl_lv_a;
  wire [3:0] irl_lv_b;
  wire [3:0] irl_lv;

  picic_irl_filter u_irl_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pins    (encoded_level_lines),
    .enable  (1'b1),
    .level   (irl_lv_a)
  );

  picic_irl_filter u_irl_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pins    (second_encoded_level_lines),
    .enable  (lvl2_en),
    .level   (irl_lv_b)
  );

  assign irl_lv = (irl_lv_a > irl_lv_b) ? irl_lv_a : irl_lv_b;

  ////////////////////////////////////////////////////////////////////////
  // port lines: aux control bit high selects active-high
  wire [15:0] port_act;
  wire        port_lo;
  wire        port_hi;

  assign port_act = ~(port_request_lines ^ line_aux_control_q) & port_request_enable_q;
  assign port_lo  = |port_act[7:0];
  assign port_hi  = |port_act[15:8];

  ////////////////////////////////////////////////////////////////////////
  // source table: 0 encoded, 1-6 external, 7-8 port, then peripherals
  wire [NSRC-1:0]   src_act;
  wire [4*NSRC-1:0] src_lv;
  wire [47:0]       per_prio;

  assign per_prio = {priority_set_e_q, priority_set_b_q, priority_set_a_q};

  assign src_act[0]   = (irl_lv != 4'h0);
  assign src_act[6:1] = ext_flag;
  assign src_act[7]   = port_lo;
  assign src_act[8]   = port_hi;
  assign src_act[NSRC-1:9] = periph_req;

  // external lines 0-3 in one register, 4-5 and the port groups in another
  assign src_lv[3:0]   = irl_lv;
  assign src_lv[19:4]  = priority_set_c_q;
  assign src_lv[27:20] = priority_set_d_q[7:0];
  assign src_lv[31:28] = priority_set_d_q[15:12];
  assign src_lv[35:32] = priority_set_d_q[11:8];
  assign src_lv[4*NSRC-1:36] = per_prio[4*NPER-1:0];

  ////////////////////////////////////////////////////////////////////////
  // arbitration; on equal level the lower source index wins
  reg [4:0] best_lv;
  reg [4:0] best_src;
  reg [4:0] cand_lv;
  integer   i;

  always @* begin
    best_lv  = `PICIC_PRIO_NONE;
    best_src = 5'h00;
    cand_lv  = `PICIC_PRIO_NONE;
    for (i = 0; i < NSRC; i = i + 1) begin
      cand_lv = src_act[i] ? {1'b0, src_lv[4*i+:4]} : `PICIC_PRIO_NONE;
      if (cand_lv > best_lv) begin
        best_lv  = cand_lv;
        best_src = i[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nonmaskable detection
  wire nmi_edge;
  wire nmi_take;

  assign nmi_edge = nonmaskable_edge_select_q ? (nmi_pin & ~nmi_prev_q) : (~nmi_pin & nmi_prev_q);

  always @(posedge clk) begin
    if (sys_rst) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      nmi_hold_q <= 5'h00;
    end else begin
      nmi_prev_q <= nmi_pin;
      // the pin is not retimed, so a changed edge select can look like an edge
      if (wr_nmi && (reg_wdata[`PICIC_NONMASKABLE_EDGE_SELECT_BIT] != nonmaskable_edge_select_q)) begin
        nmi_hold_q <= `PICIC_NMI_HOLD;
      end else if (nmi_hold_q != 5'h00) begin
        nmi_hold_q <= nmi_hold_q - 5'h01;
      end
      if (nmi_edge && (nmi_hold_q == 5'h00)) begin
        nmi_pend_q <= 1'b1;
      end else if (nmi_ack) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // the block flag is ignored while the core is asleep
  assign nmi_take = nmi_pend_q && !disable_all_bit &&
                    (block_override_bit || !exception_block_flag || sleep_mode || standby_mode);

  ////////////////////////////////////////////////////////////////////////
  // requests to the core; the mask level is only an input here
  wire mask_pass;

  assign mask_pass = (best_lv > {1'b0, processor_mask_level});

  assign cpu_req   = nmi_take || mask_pass;
  assign cpu_level = nmi_take ? `PICIC_PRIO_NMI : (mask_pass ? best_lv : `PICIC_PRIO_NONE);
  assign cpu_src   = nmi_take ? `PICIC_SRC_NMI : (mask_pass ? best_src : 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // standby wake
  reg ext_wake;
  integer k;

  always @* begin
    ext_wake = 1'b0;
    for (k = 0; k < `PICIC_WAKE_LINES; k = k + 1) begin
      if (ext_flag[k] && (src_lv[4*(k+1)+:4] > processor_mask_level)) begin
        ext_wake = 1'b1;
      end
    end
  end

  assign wakeup = standby_mode &&
                  ((nmi_pend_q && !disable_all_bit) ||
                   (rtc_osc_on && ext_wake));

  ////////////////////////////////////////////////////////////////////////
  // bus request notify while the bus is given away
  assign bus_request_notify = bus_released &&
                              ((best_lv != `PICIC_PRIO_NONE) || nmi_pend_q || refresh_req);

  ////////////////////////////////////////////////////////////////////////
  // register reads
  assign ext_pending_flags    = {port_lo, port_hi, ext_flag};
  assign pending_flags_second = periph_req[7:0];
  assign pending_flags_third  = {4'h0, periph_req[NPER-1:8]};
  // the top bit follows the pin, giving the pin-dependent reset value
  assign nmi_ctl_rd = {nmi_pin, 6'h00, nonmaskable_edge_select_q, 8'h00};

  always @* begin
    case (reg_addr)
      `PICIC_A_NMI_CTL:  rdata_d = nmi_ctl_rd;
      `PICIC_A_SENSE:    rdata_d = line_sense_control_q;
      `PICIC_A_AUX:      rdata_d = line_aux_control_q;
      `PICIC_A_PORT_EN:  rdata_d = port_request_enable_q;
      `PICIC_A_PRIO_A:   rdata_d = priority_set_a_q;
      `PICIC_A_PRIO_B:   rdata_d = priority_set_b_q;
      `PICIC_A_PRIO_C:   rdata_d = priority_set_c_q;
      `PICIC_A_PRIO_D:   rdata_d = priority_set_d_q;
      `PICIC_A_PRIO_E:   rdata_d = priority_set_e_q;
      `PICIC_A_EXT_PEND: rdata_d = {8'h00, ext_pending_flags};
      `PICIC_A_PEND_2:   rdata_d = {8'h00, pending_flags_second};
      `PICIC_A_PEND_3:   rdata_d = {8'h00, pending_flags_third};
      default:           rdata_d = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= `PICIC_RST16;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `PICIC_RST16;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// ===== bench/picic_props.sv
// Purpose: port-level checks of the priority interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to picic_top, watches what the design drives
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_props (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // register port
  input wire [31:0] reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // sources and core state
  input wire        nmi_pin,
  input wire [3:0]  encoded_level_lines,
  input wire [3:0]  processor_mask_level,
  input wire        standby_mode,
  input wire        bus_released,
  input wire        refresh_req,
  // outputs
  input wire        cpu_req,
  input wire [4:0]  cpu_level,
  input wire [4:0]  cpu_src,
  input wire        wakeup,
  input wire        bus_request_notify
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [4:0] enc_lvl = 5'h0F - {1'b0, encoded_level_lines};
  wire [4:0] mask5   = {1'b0, processor_mask_level};
  ////////////////////////////////////////////////////////////
  a_no_zero_level: assert property (cpu_req |-> cpu_level != 5'h00)
    else $error("request forwarded at level zero");
  a_idle_quiet: assert property (!cpu_req |-> cpu_level == 5'h00 && cpu_src == 5'h00)
    else $error("level or source shown without a request");
  a_nmi_top_level: assert property (cpu_req && cpu_src == `PICIC_SRC_NMI |-> cpu_level == `PICIC_PRIO_NMI)
    else $error("nonmaskable request not at top level");
  a_mask_gate: assert property (cpu_req && cpu_src != `PICIC_SRC_NMI |-> cpu_level > mask5)
    else $error("maskable request not above mask level");
  a_notify_gate: assert property (!bus_released |-> !bus_request_notify)
    else $error("notify raised while bus held");
  a_notify_refresh: assert property (bus_released && refresh_req |-> bus_request_notify)
    else $error("refresh pending without notify");
  a_wake_standby: assert property (wakeup |-> standby_mode)
    else $error("wakeup outside standby");
  a_pin_status: assert property (reg_rd && reg_addr == `PICIC_A_NMI_CTL ##1 $stable(nmi_pin)
    |-> reg_rdata[15] == nmi_pin)
    else $error("pin status bit wrong");
  a_encoded_decode: assert property ($stable(encoded_level_lines) [*3] ##0 enc_lvl > mask5
    |-> cpu_req && cpu_level >= enc_lvl)
    else $error("encoded level not presented");
endmodule

bind picic_top picic_props picic_props_inst (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .nmi_pin,
  .encoded_level_lines, .processor_mask_level, .standby_mode, .bus_released, .refresh_req, .cpu_req,
  .cpu_level, .cpu_src, .wakeup, .bus_request_notify);

// ===== bench/picic_core_model.sv
// Purpose: cpu core model that takes nonmaskable requests
// Assumes: source code 31 marks the nonmaskable request
// Notes:   acknowledges promptly or after a slow delay
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_core_model (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // bench control
  input  wire       take_en,
  input  wire       slow,
  // controller side
  input  wire       cpu_req,
  input  wire [4:0] cpu_src,
  output reg        nmi_ack
);
  reg [2:0] wait_q;
  // a taken handler never returns, so no saved state is ever restored
  always @(posedge clk) begin
    if (sys_rst) begin
      wait_q  <= 3'h0;
      nmi_ack <= 1'b0;
    end else begin
      nmi_ack <= 1'b0;
      wait_q  <= 3'h0;
      // skip the cycle after a pulse: the request drops only then
      if (take_en && cpu_req && cpu_src == `PICIC_SRC_NMI && !nmi_ack) begin
        wait_q <= wait_q + 3'h1;
        if (wait_q >= (slow ? 3'h4 : 3'h0))
          nmi_ack <= 1'b1;
      end
    end
  end
endmodule

// ===== bench/picic_top_bench.sv
// Purpose: self-checking bench of the priority interrupt controller
// Assumes: 20 MHz clock, synchronous reset
// Notes:   register strobes last one cycle; outputs sampled at falling edge
`timescale 1ns/1ps
`include "picic_consts.vh"

module picic_top_bench;
  reg        clk, sys_rst, reg_wr, reg_rd, nmi_pin, refresh_req, exception_block_flag;
  reg        sleep_mode, standby_mode, rtc_osc_on, bus_released, take_en, slow;
  reg [31:0] reg_addr;
  reg [15:0] reg_wdata, port_request_lines, rd;
  reg [11:0] periph_req;
  reg [5:0]  ext_request_lines;
  reg [3:0]  encoded_level_lines, second_encoded_level_lines, processor_mask_level;
  wire [15:0] reg_rdata;
  wire [4:0] cpu_level, cpu_src;
  wire       cpu_req, wakeup, bus_request_notify, nmi_ack;
  integer    n_mismatch, compares, i;

  picic_top #(.NPER(12)) picic_top_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nmi_pin, .ext_request_lines, .encoded_level_lines, .second_encoded_level_lines,
    .port_request_lines, .periph_req, .refresh_req, .processor_mask_level, .exception_block_flag,
    .sleep_mode, .standby_mode, .rtc_osc_on, .bus_released, .nmi_ack, .cpu_req, .cpu_level, .cpu_src,
    .wakeup, .bus_request_notify);
  picic_core_model picic_core_model_inst (.clk, .sys_rst, .take_en, .slow, .cpu_req, .cpu_src, .nmi_ack);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  function [31:0] adr(input [3:0] k);
    begin
      if (k < 4'h2)
        adr = 32'hFFFFFEE2 + {k, 1'b0};
      else if (k < 4'h5)
        adr = 32'h04000000 + {k, 1'b0};
      else
        adr = 32'h04000006 + {k, 1'b0};
    end
  endfunction
  task do_reset;
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
    end
  endtask
  task wr_reg(input [31:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task chk_reg(input [31:0] a, input [15:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      rd = reg_rdata;
      compares = compares + 1;
      if (rd !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error reg %h expected %h seen %h", a, e, rd);
      end
    end
  endtask
  task chk_out(input r, input [4:0] l, input [4:0] s, input w, input n);
    begin
      @(negedge clk);
      compares = compares + 1;
      if ({cpu_req, cpu_level, cpu_src, wakeup, bus_request_notify} !== {r, l, s, w, n}) begin
        n_mismatch = n_mismatch + 1;
        $display("Error outputs expected %h seen %h", {r, l, s, w, n},
          {cpu_req, cpu_level, cpu_src, wakeup, bus_request_notify});
      end
    end
  endtask
  // pins held three cycles so edge sampling always sees them
  task pin_nmi(input v);
    begin
      @(posedge clk);
      nmi_pin <= v;
      repeat (3) @(posedge clk);
    end
  endtask
  task set_ext(input [5:0] v);
    begin
      @(posedge clk);
      ext_request_lines <= v;
      repeat (3) @(posedge clk);
    end
  endtask
  task ack_nmi(input s);
    begin
      @(posedge clk);
      take_en <= 1'b1;
      slow    <= s;
      repeat (8) @(posedge clk);
      take_en <= 1'b0;
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, nmi_pin, reg_wr, reg_rd, refresh_req, exception_block_flag} = 6'h30;
    {sleep_mode, standby_mode, rtc_osc_on, bus_released, take_en, slow} = 6'h00;
    {encoded_level_lines, second_encoded_level_lines, processor_mask_level} = 12'hFF0;
    {reg_addr, reg_wdata} = 48'h0;
    ext_request_lines = 6'h3F;
    port_request_lines = 16'hFFFF;
    periph_req = 12'h000;
    n_mismatch = 0;
    compares = 0;
    do_reset;
    chk_reg(`PICIC_A_NMI_CTL, 16'h8000);
    for (i = 0; i < 11; i = i + 1)
      chk_reg(adr(i[3:0]), 16'h0000);
    chk_reg(32'h04000002, 16'h0000);
    for (i = 0; i < 11; i = i + 1)
      if (i != 2) begin
        wr_reg(adr(i[3:0]), {8'hC3, i[7:0]});
        chk_reg(adr(i[3:0]), (i > 2 && i < 5) ? 16'h0000 : {8'hC3, i[7:0]});
      end
    $display("test registers done");
    @(posedge clk);
    nmi_pin <= 1'b0;
    do_reset;
    chk_reg(`PICIC_A_NMI_CTL, 16'h0000);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    @(posedge clk);
    processor_mask_level <= 4'hF;
    pin_nmi(1'b1);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    pin_nmi(1'b0);
    chk_out(1'h1, 5'h10, 5'h1F, 1'h0, 1'h0);
    ack_nmi(1'b1);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    exception_block_flag <= 1'b1;
    pin_nmi(1'b1);
    pin_nmi(1'b0);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    @(posedge clk);
    sleep_mode <= 1'b1;
    chk_out(1'h1, 5'h10, 5'h1F, 1'h0, 1'h0);
    @(posedge clk);
    {sleep_mode, standby_mode} <= 2'h1;
    chk_out(1'h1, 5'h10, 5'h1F, 1'h1, 1'h0);
    wr_reg(`PICIC_A_SENSE, 16'h8000);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    wr_reg(`PICIC_A_SENSE, 16'h2000);
    standby_mode <= 1'b0;
    chk_out(1'h1, 5'h10, 5'h1F, 1'h0, 1'h0);
    ack_nmi(1'b0);
    exception_block_flag <= 1'b0;
    wr_reg(`PICIC_A_SENSE, 16'h0000);
    wr_reg(`PICIC_A_NMI_CTL, 16'h0100);
    pin_nmi(1'b1);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    chk_reg(`PICIC_A_NMI_CTL, 16'h8100);
    pin_nmi(1'b0);
    repeat (20) @(posedge clk);
    pin_nmi(1'b1);
    chk_out(1'h1, 5'h10, 5'h1F, 1'h0, 1'h0);
    ack_nmi(1'b1);
    $display("test nonmaskable done");
    // sense rewritten under full mask; the pending write before unmasking clears nothing, as no flag was read
    processor_mask_level <= 4'hF;
    wr_reg(`PICIC_A_SENSE, 16'h0009);
    set_ext(6'h3E);
    wr_reg(`PICIC_A_EXT_PEND, 16'h0000);
    wr_reg(`PICIC_A_PRIO_C, 16'h0075);
    processor_mask_level <= 4'h3;
    set_ext(6'h3F);
    chk_out(1'h1, 5'h05, 5'h01, 1'h0, 1'h0);
    set_ext(6'h3D);
    chk_out(1'h1, 5'h07, 5'h02, 1'h0, 1'h0);
    set_ext(6'h3F);
    {standby_mode, rtc_osc_on} <= 2'h3;
    chk_out(1'h1, 5'h05, 5'h01, 1'h1, 1'h0);
    @(posedge clk);
    rtc_osc_on <= 1'b0;
    chk_out(1'h1, 5'h05, 5'h01, 1'h0, 1'h0);
    @(posedge clk);
    standby_mode <= 1'b0;
    processor_mask_level <= 4'h5;
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    @(posedge clk);
    processor_mask_level <= 4'h3;
    wr_reg(`PICIC_A_EXT_PEND, 16'h0000);
    chk_out(1'h1, 5'h05, 5'h01, 1'h0, 1'h0);
    chk_reg(`PICIC_A_EXT_PEND, 16'h0001);
    wr_reg(`PICIC_A_EXT_PEND, 16'h0000);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    $display("test lines done");
    wr_reg(`PICIC_A_PRIO_A, 16'h9000);
    periph_req <= 12'h208;
    chk_out(1'h1, 5'h09, 5'h0C, 1'h0, 1'h0);
    chk_reg(`PICIC_A_PEND_2, 16'h0008);
    chk_reg(`PICIC_A_PEND_3, 16'h0002);
    @(posedge clk);
    bus_released <= 1'b1;
    chk_out(1'h1, 5'h09, 5'h0C, 1'h0, 1'h1);
    @(posedge clk);
    {periph_req, refresh_req} <= 13'h0001;
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h1);
    @(posedge clk);
    bus_released <= 1'b0;
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    // one low-active port line in the upper group
    wr_reg(`PICIC_A_PRIO_D, 16'h0B00);
    wr_reg(`PICIC_A_PORT_EN, 16'h0100);
    port_request_lines <= 16'hFEFF;
    chk_out(1'h1, 5'h0B, 5'h08, 1'h0, 1'h0);
    chk_reg(`PICIC_A_EXT_PEND, 16'h0040);
    $display("test sources done");
    @(posedge clk);
    {refresh_req, processor_mask_level} <= 5'h00;
    port_request_lines <= 16'hFFFF;
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk);
      encoded_level_lines <= i[3:0];
      repeat (3) @(posedge clk);
      chk_out(i < 15, 5'h0F - i[4:0], 5'h00, 1'h0, 1'h0);
    end
    // second set counts only once both enable bits are written
    @(posedge clk);
    second_encoded_level_lines <= 4'h2;
    repeat (3) @(posedge clk);
    chk_out(1'h0, 5'h00, 5'h00, 1'h0, 1'h0);
    wr_reg(`PICIC_A_SENSE, 16'h5000);
    chk_out(1'h1, 5'h0D, 5'h00, 1'h0, 1'h0);
    $display("test encoded done");
    complete_run;
  end
endmodule
